// *** logic/pms_params.svh ***
// constants of the programmable mealy sequencer: sizes, offsets, fields, reset values
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

`define PMS_N_IN          16
`define PMS_N_STATE       6
`define PMS_N_OUT         8
`define PMS_N_TERM        48
`define PMS_N_VAR         23
`define PMS_N_REG         14
`define PMS_ADDR_W        10

`define PMS_OFF_CTRL      10'h000
`define PMS_OFF_STATUS    10'h004
`define PMS_OFF_FLAGS     10'h008
`define PMS_TERM_BASE_HI  6'h10

`define PMS_W_ONE         2'h0
`define PMS_W_ZERO        2'h1
`define PMS_W_SET         2'h2
`define PMS_W_RST         2'h3

`define PMS_CTRL_OE_BIT   0
`define PMS_CTRL_LOCK_BIT 1
`define PMS_FLAG_CONF_BIT 0
`define PMS_COMP_LINK_BIT 16
`define PMS_C_VAR_BIT     22

`define PMS_STATE_RST     6'h3f
`define PMS_OUT_RST       8'hff
`define PMS_DIAG_HI       2'h3
`define PMS_OE_OFF        8'hff
`define PMS_OE_ON         8'h00

`endif

// *** logic/pms_pkg.sv ***
// types shared by the programmable mealy sequencer
`include "pms_params.svh"
package pms_pkg;

  // one transition term: and-array links, complement link and or-array commands
  typedef struct packed {
    logic [`PMS_N_VAR-1:0] must_one;
    logic [`PMS_N_VAR-1:0] must_zero;
    logic                  comp_link;
    logic [`PMS_N_REG-1:0] set_cmd;
    logic [`PMS_N_REG-1:0] rst_cmd;
  } pms_term_t;

  // pins after filtering
  typedef struct packed {
    logic                 seq_clk;
    logic                 ctrl;
    logic                 diag;
    logic [`PMS_N_IN-1:0] data;
  } pms_pins_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_DONE
  } pms_bus_st_t;

endpackage : pms_pkg

// *** logic/pms_sync.sv ***
// three-stage pin synchroniser; a level is taken once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pms_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_next;

  initial begin
    if (W < 1) $error("pms_sync: width must be positive");
  end

  assign level_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (level_o & (s2_reg ^ s3_reg));

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      level_o <= '0;
    end else begin
      s1_reg  <= pin_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      level_o <= level_next;
    end
  end

  // rst_val_i is unused by design in this build; reset level is zero
  logic unused_ok;
  assign unused_ok = ^rst_val_i;

endmodule : pms_sync
`default_nettype wire

// *** logic/pms_top.sv ***
// programmable mealy sequencer: term arrays, s/r registers, pin logic and avalon slave
// Operation
// RQ1 - six-bit state register and eight-bit output register of set/reset flip-flops
// RQ2 - power-on forces every state and output bit to one
// RQ3 - and array joins sixteen inputs and six state bits into 48 terms
// RQ4 - terms use true, false or don't care; or array acts on clock rise
// RQ5 - optional complement array yields a variable for true and complemented terms
// RQ6 - control pin is either active-high preset or active-low output enable
// RQ7 - both registers change only on a rising clock transition
// RQ8 - normally the eight outputs show the output register when enabled
// RQ9 - diagnostic level shows state bits on outputs 0-5, ones on 6-7
// RQ10 - output register keeps its contents during diagnostic mode
// RQ11 - preset high sets all bits, blocks clocking and drives outputs high
// RQ12 - after preset, clocking resumes after the next falling clock transition
// RQ13 - output enable low drives outputs, high switches them off
// RQ14 - simultaneous set and reset on one flip-flop gives an undefined result
// RQ15 - preset and output enable are exclusive, chosen by one-time option
// RQ16 - set alone gives one, reset alone zero, neither holds
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "pms_params.svh"
module pms_top #(
  parameter int N_TERM = `PMS_N_TERM
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic [`PMS_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic                   seq_clk_i,
  input  wire logic [`PMS_N_IN-1:0]   logic_in_i,
  input  wire logic                   init_or_drive_control_i,
  input  wire logic                   diagnostic_input_i,
  output logic      [`PMS_N_OUT-1:0]  out_o,
  output logic      [`PMS_N_OUT-1:0]  out_oe_n_o
);

  initial begin
    if (N_TERM < 1 || N_TERM > `PMS_N_TERM) $error("pms_top: N_TERM must be 1..48");
  end

  // ---------------------------------------------------------------- functions
  function automatic logic term_hit(input pms_pkg::pms_term_t t,
                                    input logic [`PMS_N_VAR-1:0] v,
                                    input logic use_c);
    logic [`PMS_N_VAR-1:0] one;
    logic [`PMS_N_VAR-1:0] zero;
    one  = t.must_one;
    zero = t.must_zero;
    one[`PMS_C_VAR_BIT]  = one[`PMS_C_VAR_BIT] & use_c;
    zero[`PMS_C_VAR_BIT] = zero[`PMS_C_VAR_BIT] & use_c;
    // a var with both links intact can never match, so the term is inhibited
    return ((v & one) == one) && ((~v & zero) == zero);
  endfunction : term_hit

  function automatic logic [`PMS_N_REG-1:0] sr_next(input logic [`PMS_N_REG-1:0] q,
                                                    input logic [`PMS_N_REG-1:0] s,
                                                    input logic [`PMS_N_REG-1:0] r);
    // conflicting bits hold their value
    return (q & ~(s ^ r)) | (s & ~r);
  endfunction : sr_next

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  // ---------------------------------------------------------------- pins
  pms_pkg::pms_pins_t pins;

  pms_sync #(
    .W ($bits(pms_pkg::pms_pins_t))
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      ({seq_clk_i, init_or_drive_control_i, diagnostic_input_i, logic_in_i}),
    .rst_val_i  ('0),
    .level_o    (pins)
  );

  // ---------------------------------------------------------------- state
  pms_pkg::pms_term_t          prog_reg [N_TERM];
  logic [`PMS_N_STATE-1:0]     state_reg;
  logic [`PMS_N_STATE-1:0]     state_next;
  logic [`PMS_N_OUT-1:0]       outreg_reg;
  logic [`PMS_N_OUT-1:0]       outreg_next;
  logic                        ck_prev_reg;
  logic                        armed_reg;
  logic                        armed_next;
  logic                        cfg_oe_reg;
  logic                        cfg_lock_reg;
  logic                        conflict_reg;
  logic                        conflict_next;
  logic [`PMS_N_OUT-1:0]       out_next;
  logic [`PMS_N_OUT-1:0]       oe_n_next;
  pms_pkg::pms_bus_st_t        bus_st_reg;

  // ---------------------------------------------------------------- control pin
  logic ck_rise;
  logic ck_fall;
  logic preset;
  logic drive_off;
  logic diag;
  logic step;

  assign ck_rise   = pins.seq_clk & ~ck_prev_reg;
  assign ck_fall   = ~pins.seq_clk & ck_prev_reg;
  assign preset    = ~cfg_oe_reg & pins.ctrl;   // RQ6 RQ15
  assign drive_off = cfg_oe_reg & pins.ctrl;    // RQ6 RQ15
  assign diag      = pins.diag;
  assign step      = ck_rise & armed_reg & ~preset;  // RQ7 RQ11 RQ12

  // ---------------------------------------------------------------- arrays
  logic [N_TERM-1:0]         hit_pass1;
  logic [N_TERM-1:0]         hit_pass2;
  logic [N_TERM-1:0]         comp_links;
  logic                      c_var;
  logic [`PMS_N_VAR-1:0]     vars_pass1;
  logic [`PMS_N_VAR-1:0]     vars_pass2;
  logic [`PMS_N_REG-1:0]     set_all;
  logic [`PMS_N_REG-1:0]     rst_all;
  logic [`PMS_N_STATE-1:0]   st_set;
  logic [`PMS_N_STATE-1:0]   st_rst;
  logic [`PMS_N_REG-1:0]     sr_res;

  assign vars_pass1 = {1'b0, state_reg, pins.data};  // RQ3
  assign vars_pass2 = {c_var, state_reg, pins.data}; // RQ3 RQ5

  // two passes through the and array keep the complement path free of loops
  for (genvar g = 0; g < N_TERM; g++) begin : g_term
    assign hit_pass1[g]  = term_hit(prog_reg[g], vars_pass1, 1'b0);  // RQ4
    assign hit_pass2[g]  = term_hit(prog_reg[g], vars_pass2, 1'b1);  // RQ4
    assign comp_links[g] = prog_reg[g].comp_link;
  end

  assign c_var = ~|(hit_pass1 & comp_links);  // RQ5

  always_comb begin
    set_all = '0;
    rst_all = '0;
    for (int i = 0; i < N_TERM; i++) begin
      if (hit_pass2[i]) begin
        set_all = set_all | prog_reg[i].set_cmd;  // RQ4
        rst_all = rst_all | prog_reg[i].rst_cmd;  // RQ4
      end
    end
  end

  assign st_set = set_all[`PMS_N_REG-1:`PMS_N_OUT];
  assign st_rst = rst_all[`PMS_N_REG-1:`PMS_N_OUT];
  assign sr_res = sr_next({state_reg, outreg_reg}, set_all, rst_all);  // RQ16

  // ---------------------------------------------------------------- next values
  assign state_next  = preset ? `PMS_STATE_RST :
                       step   ? sr_res[`PMS_N_REG-1:`PMS_N_OUT] : state_reg;       // RQ7 RQ11
  assign outreg_next = preset         ? `PMS_OUT_RST :
                       (step & ~diag) ? sr_res[`PMS_N_OUT-1:0] : outreg_reg;       // RQ10 RQ11
  assign armed_next  = preset ? 1'b0 : (ck_fall ? 1'b1 : armed_reg);               // RQ12
  assign out_next    = diag ? {`PMS_DIAG_HI, state_next} : outreg_next;            // RQ8 RQ9
  assign oe_n_next   = drive_off ? `PMS_OE_OFF : `PMS_OE_ON;                       // RQ13

  // ---------------------------------------------------------------- bus decode
  logic                 bus_req;
  logic                 wr_fire;
  logic [5:0]           term_idx;
  logic                 term_ok;
  logic                 hit_ctrl;
  logic                 hit_flags;
  logic [1:0]           word_sel;
  logic [31:0]          rd_word;
  logic [31:0]          term_word;
  logic [31:0]          status_word;
  pms_pkg::pms_term_t   sel_term;
  logic                 conf_clear;
  logic [31:0]          wr_merged;

  assign bus_req     = avs_read_i | avs_write_i;
  assign wr_fire     = (bus_st_reg == pms_pkg::BUS_DONE) & avs_write_i;
  assign term_idx    = avs_address_i[9:4] - `PMS_TERM_BASE_HI;
  assign word_sel    = avs_address_i[3:2];
  assign term_ok     = (avs_address_i[9:8] != 2'h0) && (32'(term_idx) < N_TERM) && (avs_address_i[1:0] == 2'h0);
  assign hit_ctrl    = avs_address_i == `PMS_OFF_CTRL;
  assign hit_flags   = avs_address_i == `PMS_OFF_FLAGS;
  assign sel_term    = term_ok ? prog_reg[term_idx] : '0;
  assign term_word   = (word_sel == `PMS_W_ONE)  ? {9'h0, sel_term.must_one} :
                       (word_sel == `PMS_W_ZERO) ? {9'h0, sel_term.must_zero} :
                       (word_sel == `PMS_W_SET)  ? {15'h0, sel_term.comp_link, 2'h0, sel_term.set_cmd} :
                                                   {18'h0, sel_term.rst_cmd};
  assign status_word = {13'h0, diag, preset, armed_reg, outreg_reg, 2'h0, state_reg};
  assign rd_word     = hit_ctrl                            ? {30'h0, cfg_lock_reg, cfg_oe_reg} :
                       (avs_address_i == `PMS_OFF_STATUS)  ? status_word :
                       hit_flags                           ? {31'h0, conflict_reg} :
                       term_ok                             ? term_word : 32'h0;
  assign conf_clear  = wr_fire & hit_flags & avs_byteenable_i[0] & avs_writedata_i[`PMS_FLAG_CONF_BIT];
  assign wr_merged   = merge(term_word, avs_writedata_i, avs_byteenable_i);
  // a conflict in the clearing cycle is kept
  assign conflict_next = (step & |(set_all & rst_all)) | (conflict_reg & ~conf_clear);  // RQ14

  // ---------------------------------------------------------------- registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg  <= `PMS_STATE_RST;  // RQ1 RQ2
      outreg_reg <= `PMS_OUT_RST;    // RQ1 RQ2
    end else begin
      state_reg  <= state_next;      // RQ1 RQ7
      outreg_reg <= outreg_next;     // RQ1 RQ7
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ck_prev_reg  <= 1'b0;
      armed_reg    <= 1'b0;          // RQ12
      conflict_reg <= 1'b0;
      out_o        <= `PMS_OUT_RST;  // RQ2
      out_oe_n_o   <= `PMS_OE_ON;
    end else begin
      ck_prev_reg  <= pins.seq_clk;
      armed_reg    <= armed_next;
      conflict_reg <= conflict_next;
      out_o        <= out_next;
      out_oe_n_o   <= oe_n_next;
    end
  end

  // option is one-time: once locked it stays until reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_oe_reg   <= 1'b0;
      cfg_lock_reg <= 1'b0;
    end else if (wr_fire && hit_ctrl && avs_byteenable_i[0] && !cfg_lock_reg) begin
      cfg_oe_reg   <= avs_writedata_i[`PMS_CTRL_OE_BIT];    // RQ15
      cfg_lock_reg <= avs_writedata_i[`PMS_CTRL_LOCK_BIT];  // RQ15
    end
  end

  // after reset every term is inhibited and drives no command
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N_TERM; i++) begin
        prog_reg[i] <= '{must_one: '1, must_zero: '1, comp_link: 1'b0, set_cmd: '0, rst_cmd: '0};
      end
    end else if (wr_fire && term_ok) begin
      case (word_sel)
        `PMS_W_ONE:  prog_reg[term_idx].must_one  <= wr_merged[`PMS_N_VAR-1:0];
        `PMS_W_ZERO: prog_reg[term_idx].must_zero <= wr_merged[`PMS_N_VAR-1:0];
        `PMS_W_SET: begin
          prog_reg[term_idx].set_cmd   <= wr_merged[`PMS_N_REG-1:0];
          prog_reg[term_idx].comp_link <= wr_merged[`PMS_COMP_LINK_BIT];
        end
        default:     prog_reg[term_idx].rst_cmd   <= wr_merged[`PMS_N_REG-1:0];
      endcase
    end
  end

  // one wait state: answer on the cycle after the request is seen
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bus_st_reg        <= pms_pkg::BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      case (bus_st_reg)
        pms_pkg::BUS_IDLE: begin
          if (bus_req) begin
            bus_st_reg        <= pms_pkg::BUS_DONE;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= avs_read_i ? rd_word : avs_readdata_o;
          end
        end
        pms_pkg::BUS_DONE: begin
          bus_st_reg        <= pms_pkg::BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_st_reg        <= pms_pkg::BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------- checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_reset_ones;
    $rose(rst_n_i) |-> (state_reg == `PMS_STATE_RST) && (outreg_reg == `PMS_OUT_RST);
  endproperty
  a_reset_ones: assert property (p_reset_ones) else $error("registers not all ones after reset"); // RQ2

  property p_preset_force;
    preset |=> (state_reg == `PMS_STATE_RST) && (outreg_reg == `PMS_OUT_RST) && (out_o == `PMS_OUT_RST);
  endproperty
  a_preset_force: assert property (p_preset_force) else $error("preset did not force ones"); // RQ11

  property p_hold_no_edge;
    !step && !preset |=> $stable(state_reg) && $stable(outreg_reg);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) else $error("register changed without clock rise"); // RQ7

  property p_rearm_after_fall;
    preset ##1 (!preset && !ck_fall)[*2] |-> !armed_reg && !step;
  endproperty
  a_rearm_after_fall: assert property (p_rearm_after_fall) else $error("clocking resumed before fall"); // RQ12

  property p_diag_view;
    diag |=> out_o == {`PMS_DIAG_HI, state_reg};
  endproperty
  a_diag_view: assert property (p_diag_view) else $error("diagnostic view wrong"); // RQ9

  property p_diag_hold;
    diag && !preset |=> $stable(outreg_reg);
  endproperty
  a_diag_hold: assert property (p_diag_hold) else $error("output register changed in diagnostic mode"); // RQ10

  property p_normal_out;
    !diag && !drive_off |=> (out_o == outreg_reg) && (out_oe_n_o == `PMS_OE_ON);
  endproperty
  a_normal_out: assert property (p_normal_out) else $error("outputs do not show output register"); // RQ8

  property p_drive_off;
    drive_off |=> out_oe_n_o == `PMS_OE_OFF;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("outputs not off while enable high"); // RQ13

  property p_set_reset;
    step && ((st_set & st_rst) == '0) |=>
      ((state_reg & $past(st_set)) == $past(st_set)) && ((state_reg & $past(st_rst)) == '0);
  endproperty
  a_set_reset: assert property (p_set_reset) else $error("set or reset not applied"); // RQ16

  property p_conflict_flag;
    step && (|(set_all & rst_all)) |=> conflict_reg;
  endproperty
  a_conflict_flag: assert property (p_conflict_flag) else $error("conflict not flagged"); // RQ14

  property p_bus_answer;
    bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one wait state");

  c_step:       cover property (step);
  c_comp_used:  cover property (step && !c_var);
  c_conflict:   cover property (step && |(set_all & rst_all));
  c_preset_run: cover property (preset ##1 !preset ##[1:40] step);

endmodule : pms_top
`default_nettype wire

// *** testbench/pms_far_end.sv ***
// far-end model: sequencer clock, logic inputs, control and diagnostic pins
`timescale 1ns/100ps
`default_nettype none
module pms_far_end (
  input  wire logic        core_clk_i,
  output logic             seq_clk_o,
  output logic [15:0]      data_o,
  output logic             ctrl_o,
  output logic             diag_o
);
  initial begin
    seq_clk_o = 1'b0;
    data_o    = 16'h0000;
    ctrl_o    = 1'b0;
    diag_o    = 1'b0;
  end
  // one full pulse, each phase longer than the pin filter; ends low so the next rise counts
  task automatic step();
    @(posedge core_clk_i);
    seq_clk_o <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    seq_clk_o <= 1'b0;
    repeat (6) @(posedge core_clk_i);
  endtask : step
  // inputs settle well before the next rise
  task automatic pins(input logic [15:0] d, input logic c, input logic g);
    @(posedge core_clk_i);
    data_o <= d;
    ctrl_o <= c;
    diag_o <= g;
    repeat (6) @(posedge core_clk_i);
  endtask : pins
endmodule : pms_far_end
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench of the programmable mealy sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pms_params.svh"
module tb_top;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  adr   = 10'h000;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wd    = 32'h0;
  logic [31:0] rdat, rv;
  logic        wreq, sclk, ctl, dg, odd, a1;
  logic [15:0] d;
  logic [15:0] d_pin;
  logic [7:0]  out, oen, ob;
  logic [5:0]  st;
  logic [4:0]  v;
  logic [13:0] s0, r0, s1, r1;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          seed        = 58199;

  always #50 clk = ~clk;

  pms_top #(.N_TERM(48)) i_pms_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .seq_clk_i(sclk), .logic_in_i(d_pin), .init_or_drive_control_i(ctl), .diagnostic_input_i(dg),
    .out_o(out), .out_oe_n_o(oen));
  pms_far_end i_pms_far_end (.core_clk_i(clk), .seq_clk_o(sclk), .data_o(d_pin), .ctrl_o(ctl), .diag_o(dg));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one avalon transfer; read data are taken at the completing edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] dat);
    @(posedge clk);
    adr <= a;
    wd  <= dat;
    wr  <= w;
    rd  <= ~w;
    do @(posedge clk); while (wreq !== 1'b0);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic term(input int n, input logic [22:0] m1, m0, input logic cl, input logic [13:0] s, r);
    logic [9:0] b;
    b = 10'h100 + 10'(n * 16);
    bus(1'b1, b, {9'h0, m1});
    bus(1'b1, b + 10'h004, {9'h0, m0});
    bus(1'b1, b + 10'h008, {15'h0, cl, 2'h0, s});
    bus(1'b1, b + 10'h00c, {18'h0, r});
  endtask : term

  task automatic status(input string nm);
    bus(1'b0, `PMS_OFF_STATUS, 32'h0);
    chk(nm, {16'h0, ob, 2'h0, st}, rv & 32'h0000ff3f);
  endtask : status

  // set alone gives one, reset alone zero, neither or both hold
  function automatic logic [13:0] nxt(input logic [13:0] q, s, r);
    return (q & ~(s ^ r)) | (s & ~r);
  endfunction : nxt

  task automatic run_step(input logic frz);
    logic [13:0] q;
    a1 = ((v < 5'd16) ? d[v[3:0]] : st[3'(v - 5'd16)]) ^ odd;
    q  = nxt({st, ob}, s0 | (a1 ? s1 : 14'h0), r0 | (a1 ? r1 : 14'h0));
    i_pms_far_end.step();
    st = q[13:8];
    if (!frz) ob = q[7:0];
  endtask : run_step

  task automatic end_of_test();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    st = 6'h3f;
    ob = 8'hff;
    d  = 16'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chk("out after reset", 32'hff, out);
    chk("oe after reset", 32'h0, oen);
    status("status after reset");
    bus(1'b0, 10'h0f0, 32'h0);
    chk("unmapped read", 32'h0, rv);
    $display("test reset done");
    term(0, 23'h0, 23'h0, 1'b0, 14'h0, 14'h0001);
    i_pms_far_end.step();
    status("first rise after reset");
    i_pms_far_end.step();
    ob = 8'hfe;
    status("first full pulse");
    $display("test arm done");
    term(2, 23'h0, 23'h2, 1'b1, 14'h0, 14'h0);
    term(3, 23'h400000, 23'h0, 1'b0, 14'h0, 14'h0100);
    i_pms_far_end.step();
    status("complement low");
    d = 16'h0002;
    i_pms_far_end.pins(d, 1'b0, 1'b0);
    i_pms_far_end.step();
    st = 6'h3e;
    status("complement high");
    term(3, 23'h7fffff, 23'h7fffff, 1'b0, 14'h0, 14'h0);
    $display("test complement done");
    for (int i = 0; i < 8; i++) begin
      s0  = 14'($random(seed));
      r0  = 14'($random(seed)) & ~s0;
      s1  = 14'($random(seed));
      r1  = 14'($random(seed)) & ~s1;
      v   = (i == 0) ? 5'd21 : 5'(($random(seed) & 32'h7fffffff) % 22);
      d   = 16'($random(seed));
      odd = i[0];
      term(0, 23'h0, 23'h0, 1'b0, s0, r0);
      term(47, odd ? 23'h0 : 23'h1 << v, odd ? 23'h1 << v : 23'h0, 1'b0, s1, r1);
      i_pms_far_end.pins(d, 1'b0, 1'b0);
      run_step(1'b0);
      status("random step");
      chk("out follows register", {24'h0, ob}, out);
    end
    $display("test random done");
    i_pms_far_end.pins(d, 1'b0, 1'b1);
    chk("diag out", {24'h0, 2'b11, st}, out);
    run_step(1'b1);
    status("diag step");
    chk("diag out after step", {24'h0, 2'b11, st}, out);
    i_pms_far_end.pins(d, 1'b0, 1'b0);
    $display("test diagnostic done");
    bus(1'b1, `PMS_OFF_FLAGS, 32'h1);
    s0 = 14'h0001;
    r0 = 14'h0001;
    s1 = 14'h0;
    r1 = 14'h0;
    term(0, 23'h0, 23'h0, 1'b0, s0, r0);
    term(47, 23'h0, 23'h0, 1'b0, s1, r1);
    bus(1'b0, `PMS_OFF_FLAGS, 32'h0);
    chk("flags cleared", 32'h0, rv & 32'h1);
    run_step(1'b0);
    status("collision holds");
    bus(1'b0, `PMS_OFF_FLAGS, 32'h0);
    chk("collision flag", 32'h1, rv & 32'h1);
    $display("test collision done");
    s0 = 14'h0;
    r0 = 14'h3fff;
    term(0, 23'h0, 23'h0, 1'b0, s0, r0);
    i_pms_far_end.pins(d, 1'b1, 1'b0);
    st = 6'h3f;
    ob = 8'hff;
    chk("preset out", 32'hff, out);
    i_pms_far_end.step();
    status("step during preset");
    i_pms_far_end.pins(d, 1'b0, 1'b0);
    i_pms_far_end.step();
    status("rise after preset");
    run_step(1'b0);
    status("full pulse after preset");
    $display("test preset done");
    bus(1'b1, `PMS_OFF_CTRL, 32'h3);
    i_pms_far_end.pins(d, 1'b1, 1'b0);
    chk("outputs off", 32'hff, oen);
    status("enable high keeps registers");
    i_pms_far_end.pins(d, 1'b0, 1'b0);
    chk("outputs on", 32'h0, oen);
    chk("enabled out", {24'h0, ob}, out);
    bus(1'b1, `PMS_OFF_CTRL, 32'h0);
    bus(1'b0, `PMS_OFF_CTRL, 32'h0);
    chk("option locked", 32'h3, rv & 32'h3);
    $display("test enable done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
